/* src/irm_pkg.sv */
// Purpose: Shared constants and types of the interpolator register bank
// Assumes: 40 MHz core clock, serial command port sampled by that clock
// Notes:   Read, write and command codes live in separate spaces
package irm_pkg;
    // Read space
    localparam logic [7:0] RD_MEASURED = 8'h00;
    localparam logic [7:0] RD_SETUP    = 8'h01;
    localparam logic [7:0] RD_PHASE    = 8'h03;
    localparam logic [7:0] RD_SINE     = 8'h04;
    localparam logic [7:0] RD_COSINE   = 8'h05;
    localparam logic [7:0] RD_COUNT    = 8'h07;
    // Write space
    localparam logic [7:0] WR_PRIMARY  = 8'h00;
    localparam logic [7:0] WR_SECOND   = 8'h01;
    localparam logic [7:0] WR_MASK     = 8'h02;
    localparam logic [7:0] WR_ALIGN    = 8'h03;
    localparam logic [7:0] WR_TEST     = 8'h04;
    localparam logic [7:0] WR_SINE_GAIN_TRIM    = 8'h07;
    localparam logic [7:0] WR_SINE_OFFSET_TRIM     = 8'h08;
    localparam logic [7:0] WR_COSINE_GAIN_TRIM    = 8'h09;
    localparam logic [7:0] WR_COSINE_OFFSET_TRIM     = 8'h0A;
    // Command space
    localparam logic [7:0] CMD_CHANNEL = 8'h00;
    localparam logic [7:0] CMD_CLR_CNT = 8'h01;
    localparam logic [7:0] CMD_MIDSCALE = 8'h02;
    // Frame field codes, bits 13:12
    localparam logic [1:0] OP_WR_ADDR  = 2'h1;
    localparam logic [1:0] OP_WR_DATA  = 2'h2;
    localparam logic [1:0] OP_WR_CMD   = 2'h3;
    localparam logic [1:0] OP_RD_LOW   = 2'h0;
    localparam logic [1:0] OP_RD_HIGH  = 2'h1;
    // Reset values
    localparam logic [7:0] SECOND_RST  = 8'h00;
    localparam logic [7:0] MASK_RST    = 8'h3F;
    localparam logic [7:0] ALIGN_RST   = 8'h00;
    localparam logic [7:0] TEST_RST    = 8'h00;
    localparam logic [7:0] GAIN_MID    = 8'h80;
    localparam logic [7:0] OFFSET_MID  = 8'h00;
    // Field positions
    localparam int TEST_STROBE_BIT = 2;
    localparam int ALIGN_FREE_BIT  = 7;
    localparam int MASK_LATCH_BIT  = 7;
    localparam int MASK_FREEZE_BIT = 6;
    localparam int SEC_EDGE_BIT    = 0;
    localparam int SEC_INDEX_BIT   = 1;
    localparam int SEC_CORR_BIT    = 2;
    localparam int FRAME_BITS      = 16;
    // Reset processing time
    localparam int INIT_CYCLES = 1365;

    typedef struct packed {
        logic overspeed_square;
        logic overspeed_main;
        logic converter_clip;
        logic low_vector_amp;
        logic offset_limit;
        logic gain_limit;
    } irm_err_t;

    typedef struct packed {
        logic [7:0] sine_gain_trim;
        logic [7:0] sine_offset_trim;
        logic [7:0] cosine_gain_trim;
        logic [7:0] cosine_offset_trim;
    } irm_corr_t;

    typedef struct packed {
        logic [2:0] interp_rate_sel;
        logic [1:0] interval_hi;
    } irm_cfg_pins_t;
endpackage

/* src/irm_register_bank.sv */
// Purpose: Register bank and command decoder behind the serial command port
// Assumes: Serial clock well below core clock, sampled and edge-detected here
// Notes:   Open-drain data out; enable high pulls the line low
`timescale 1ns/1ps
module irm_register_bank
    import irm_pkg::*;
(
    input  wire logic          core_clk_i,
    input  wire logic          rst_i,
    // Serial command port pins
    input  wire logic          sclk_i,
    input  wire logic          sen_n_i,
    input  wire logic          sdi_i,
    output logic               sdo_o,
    output logic               sdo_oe_o,
    // Other pins
    input  wire logic          trg_i,
    input  wire logic [3:0]    channel_addr_pins_i,
    input  wire irm_cfg_pins_t cfg_pins_i,
    // Datapath, same clock
    input  wire logic          count_up_i,
    input  wire logic          count_dn_i,
    input  wire irm_err_t      err_src_i,
    input  wire logic [7:0]    phase_angle_i,
    input  wire logic [7:0]    phase_step_i,
    input  wire logic [4:0]    seq_cnt_i,
    input  wire logic          corr_upd_i,
    input  wire irm_corr_t     corr_i,
    input  wire logic          ref_index_i,
    input  wire logic          par_strobe_i,
    // Configuration and status outputs
    output logic [7:0]         primary_setup_o,
    output logic [7:0]         secondary_setup_o,
    output logic [7:0]         fault_enable_mask_o,
    output logic [7:0]         test_setup_o,
    output irm_corr_t          trims_o,
    output logic               error_o,
    output logic               freeze_o,
    output logic               index_strobe_pin_o,
    output logic               ready_o
);

    // Pin synchronisers, first stage read only by second
    logic [4:0]    sy1_r, sy2_r;
    logic          sclk_d_r, trg_d_r;
    logic [3:0]    chan1_r, chan2_r;
    irm_cfg_pins_t pins1_r, pins2_r;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sy1_r    <= 5'h1E;
            sy2_r    <= 5'h1E;
            sclk_d_r <= 1'b1;
            trg_d_r  <= 1'b1;
        end else begin
            sy1_r    <= {sclk_i, sen_n_i, trg_i, sdi_i, 1'b0};
            sy2_r    <= sy1_r;
            sclk_d_r <= sy2_r[4];
            trg_d_r  <= sy2_r[2];
        end
    end

    // Slow straps, no reset needed on plain data path
    always_ff @(posedge core_clk_i) begin
        chan1_r <= channel_addr_pins_i;
        chan2_r <= chan1_r;
        pins1_r <= cfg_pins_i;
        pins2_r <= pins1_r;
    end

    logic sclk_s, sen_s, trg_s, sdi_s, sclk_rise;
    assign sclk_s    = sy2_r[4];
    assign sen_s     = ~sy2_r[3];
    assign trg_s     = sy2_r[2];
    assign sdi_s     = sy2_r[1];
    assign sclk_rise = sclk_s & ~sclk_d_r & sen_s;

    // Reset processing: port busy, straps caught at the end
    logic [10:0] init_cnt_r;
    logic        init_r, init_done;
    assign init_done = init_r && (init_cnt_r == 11'(INIT_CYCLES - 1));

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            init_cnt_r <= 11'h000;
            init_r     <= 1'b1;
        end else if (init_r) begin
            init_cnt_r <= init_cnt_r + 11'h001;
            if (init_done) begin
                init_r <= 1'b0;
            end
        end
    end

    // Frame shifter
    logic [3:0]  bit_cnt_r;
    logic [15:0] shin_r;
    logic [15:0] frame;
    logic        frame_done;
    assign frame      = {shin_r[14:0], sdi_s};
    assign frame_done = sclk_rise && (bit_cnt_r == 4'hF) && !init_r;

    always_ff @(posedge core_clk_i) begin
        if (rst_i || !sen_s) begin
            bit_cnt_r <= 4'h0;
            shin_r    <= 16'h0000;
        end else if (sclk_rise) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            shin_r    <= frame;
        end
    end

    // Frame fields
    logic [3:0] chan_addr_r;
    logic       is_read, bcast, mine;
    logic [1:0] op;
    logic [7:0] arg;
    assign is_read = frame[15];
    assign bcast   = ~frame[14];
    assign op      = frame[13:12];
    assign arg     = frame[7:0];
    assign mine    = bcast || (frame[11:8] == chan_addr_r);

    // Three separate decode spaces
    logic wr_addr, wr_data, wr_cmd, rd_low, rd_high;
    assign wr_addr = frame_done && mine && !is_read && (op == OP_WR_ADDR);
    assign wr_data = frame_done && mine && !is_read && (op == OP_WR_DATA);
    assign wr_cmd  = frame_done && mine && !is_read && (op == OP_WR_CMD);
    assign rd_low  = frame_done && mine && is_read && (op == OP_RD_LOW);
    assign rd_high = frame_done && mine && is_read && (op == OP_RD_HIGH);

    logic cmd_clr, cmd_mid;
    assign cmd_clr = wr_cmd && (arg == CMD_CLR_CNT);
    assign cmd_mid = wr_cmd && (arg == CMD_MIDSCALE);

    // Channel address, loaded only by broadcast command
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            chan_addr_r <= 4'h0;
        end else if (wr_cmd && bcast && arg == CMD_CHANNEL) begin
            chan_addr_r <= chan2_r;
        end
    end

    // Write address pointer
    logic [7:0] wptr_r;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wptr_r <= 8'h00;
        end else if (wr_addr) begin
            wptr_r <= arg;
        end
    end

    logic wr_en;
    assign wr_en = wr_data;

    // Primary setup; straps fill it when reset processing ends
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            primary_setup_o <= 8'h00;
        end else if (init_done) begin
            primary_setup_o <= {sdi_s, trg_s, pins2_r.interval_hi,
                                1'b0, pins2_r.interp_rate_sel};
        end else if (wr_en && wptr_r == WR_PRIMARY) begin
            primary_setup_o <= arg;
        end
    end

    // Small setup registers
    logic [7:0] align_r;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            secondary_setup_o   <= SECOND_RST;
            fault_enable_mask_o <= MASK_RST;
            align_r             <= ALIGN_RST;
            test_setup_o        <= TEST_RST;
        end else if (wr_en) begin
            if (wptr_r == WR_SECOND) begin
                secondary_setup_o <= arg;
            end
            if (wptr_r == WR_MASK) begin
                fault_enable_mask_o <= arg;
            end
            if (wptr_r == WR_ALIGN) begin
                align_r <= arg;
            end
            if (wptr_r == WR_TEST) begin
                test_setup_o <= arg;
            end
        end
    end

    // Trims: preset by writes, tracked from the controller otherwise
    always_ff @(posedge core_clk_i) begin
        if (rst_i || cmd_mid) begin
            trims_o <= {GAIN_MID, OFFSET_MID, GAIN_MID, OFFSET_MID};
        end else if (wr_en && wptr_r == WR_SINE_GAIN_TRIM) begin
            trims_o.sine_gain_trim <= arg;
        end else if (wr_en && wptr_r == WR_SINE_OFFSET_TRIM) begin
            trims_o.sine_offset_trim <= arg;
        end else if (wr_en && wptr_r == WR_COSINE_GAIN_TRIM) begin
            trims_o.cosine_gain_trim <= arg;
        end else if (wr_en && wptr_r == WR_COSINE_OFFSET_TRIM) begin
            trims_o.cosine_offset_trim <= arg;
        end else if (corr_upd_i && !secondary_setup_o[SEC_CORR_BIT]) begin
            trims_o <= corr_i;
        end
    end

    // Live position counter
    logic [27:0] count_r;
    always_ff @(posedge core_clk_i) begin
        if (rst_i || cmd_clr) begin
            count_r <= 28'h0000000;
        end else if (count_up_i && !count_dn_i) begin
            count_r <= count_r + 28'h0000001;
        end else if (count_dn_i && !count_up_i) begin
            count_r <= count_r - 28'h0000001;
        end
    end

    // Error sources; stored copy when latching, live event beats the clear
    irm_err_t err_st_r, err_now;
    logic     latch_on;
    assign latch_on = fault_enable_mask_o[MASK_LATCH_BIT];
    assign err_now  = err_src_i | err_st_r;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            err_st_r <= '0;
        end else if (cmd_clr) begin
            err_st_r <= latch_on ? err_src_i : '0;
        end else if (latch_on) begin
            err_st_r <= err_st_r | err_src_i;
        end
    end

    logic sensor_fault_flag, signal_loss_flag;
    assign sensor_fault_flag = err_now.converter_clip | err_now.low_vector_amp
                             | err_now.offset_limit | err_now.gain_limit;
    assign signal_loss_flag  = err_now.converter_clip | err_now.low_vector_amp;

    // Error pin and square-wave freeze, from masked sources
    logic err_any;
    assign err_any = |(err_now & fault_enable_mask_o[5:0]);

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            error_o  <= 1'b0;
            freeze_o <= 1'b0;
        end else begin
            error_o  <= err_any;
            freeze_o <= err_any & fault_enable_mask_o[MASK_FREEZE_BIT];
        end
    end

    // Trigger edge on the synchronised pin
    logic trg_evt;
    assign trg_evt = !init_r && (secondary_setup_o[SEC_EDGE_BIT] ? (trg_s & ~trg_d_r)
                                                                : (~trg_s & trg_d_r));

    // Two-deep hold: bit 0 marks slot 0 full, bit 1 slot 1 full
    logic [1:0]  hold_slot_state_r;
    logic [27:0] hold0_r;
    logic [27:0] hold1_r;
    logic        overrun_r, release_evt;
    logic [1:0]  slot_after_rel;

    always_comb begin
        slot_after_rel = hold_slot_state_r;
        if (release_evt) begin
            if (hold_slot_state_r[0]) begin
                slot_after_rel[0] = 1'b0;
            end else begin
                slot_after_rel[1] = 1'b0;
            end
        end
    end

    // New captures only while slot 1 is free; a same-cycle release is kept
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            hold_slot_state_r <= 2'h0;
            hold0_r           <= 28'h0000000;
            hold1_r           <= 28'h0000000;
        end else if (trg_evt && !hold_slot_state_r[1]) begin
            if (!slot_after_rel[0]) begin
                hold0_r           <= count_r;
                hold_slot_state_r <= 2'h1;
            end else begin
                hold1_r           <= count_r;
                hold_slot_state_r <= 2'h3;
            end
        end else begin
            hold_slot_state_r <= slot_after_rel;
        end
    end

    // Overrun: set on a refused trigger, gone once both slots drain
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            overrun_r <= 1'b0;
        end else if (trg_evt && hold_slot_state_r[1]) begin
            overrun_r <= 1'b1;
        end else if (slot_after_rel == 2'h0) begin
            overrun_r <= 1'b0;
        end
    end

    // Status byte and composite words
    logic [7:0]  status_byte;
    logic [31:0] measured_word, count_word;
    logic [27:0] oldest;
    logic        held_value_flag;
    assign held_value_flag = |hold_slot_state_r;
    assign oldest = hold_slot_state_r[0] ? hold0_r
                  : (hold_slot_state_r[1] ? hold1_r : count_r);
    assign status_byte = {hold_slot_state_r, err_now};
    assign measured_word = {oldest, err_now.overspeed_main, sensor_fault_flag,
                            overrun_r, held_value_flag};
    assign count_word = {count_r, err_now.gain_limit, err_now.offset_limit,
                         signal_loss_flag, err_now.overspeed_main};

    // Read mux; narrow registers sit low, unmapped reads give zero
    logic [31:0] rd_word;
    logic [7:0]  rd_addr_r;
    always_comb begin
        rd_word = 32'h00000000;
        unique case (rd_addr_r)
            RD_MEASURED: rd_word = measured_word;
            RD_SETUP:    rd_word = {fault_enable_mask_o, secondary_setup_o,
                                    primary_setup_o, status_byte};
            RD_PHASE:    rd_word = {8'h00, phase_step_i, 8'h00, phase_angle_i};
            RD_SINE:     rd_word = {16'h0000, trims_o.sine_offset_trim,
                                    trims_o.sine_gain_trim};
            RD_COSINE:   rd_word = {16'h0000, trims_o.cosine_offset_trim,
                                    trims_o.cosine_gain_trim};
            RD_COUNT:    rd_word = count_word;
            default:     rd_word = 32'h00000000;
        endcase
    end

    // Low-word read waits for the sequencer unless free running
    logic       pending_r, capture;
    assign capture = pending_r && (align_r[ALIGN_FREE_BIT]
                     || seq_cnt_i == align_r[4:0]);
    assign release_evt = capture && rd_addr_r == RD_MEASURED;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rd_addr_r <= 8'h00;
            pending_r <= 1'b0;
        end else if (rd_low) begin
            rd_addr_r <= arg;
            pending_r <= 1'b1;
        end else if (capture) begin
            pending_r <= 1'b0;
        end
    end

    // 32-bit hold word and outgoing shifter
    logic [31:0] hold_word_r;
    logic [15:0] shout_r;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            hold_word_r <= 32'h00000000;
            shout_r     <= 16'hFFFF;
        end else if (capture) begin
            hold_word_r <= rd_word;
            shout_r     <= rd_word[15:0];
        end else if (rd_high) begin
            shout_r <= hold_word_r[31:16];
        end else if (frame_done) begin
            shout_r <= hold_word_r[15:0];
        end else if (sclk_rise) begin
            shout_r <= {shout_r[14:0], 1'b1};
        end
    end

    // Open drain: low while busy, else the next data bit
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sdo_o    <= 1'b0;
            sdo_oe_o <= 1'b1;
            ready_o  <= 1'b0;
        end else begin
            sdo_o    <= 1'b0;
            sdo_oe_o <= init_r || pending_r || rd_low || (sen_s && !shout_r[15]);
            ready_o  <= !init_r && !pending_r;
        end
    end

    // Index or parallel strobe onto the shared pin
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            index_strobe_pin_o <= 1'b0;
        end else begin
            index_strobe_pin_o <= test_setup_o[TEST_STROBE_BIT] ? par_strobe_i
                                : (ref_index_i && !secondary_setup_o[SEC_INDEX_BIT]);
        end
    end

endmodule

/* bench/irm_host_model.sv */
// Purpose: Host side of the serial command port, one 16-bit frame per call
// Assumes: Link clock 200 ns made from the 25 ns core clock, idle low
// Notes:   Released data line shows the inverse of its last bit
`timescale 1ns/1ps
module irm_host_model (
    input  wire logic core_clk_i,
    input  wire logic sdo_line_i,
    output logic      sclk_o,
    output logic      sen_n_o,
    output logic      sdi_o
);
    // Data line high in reset, so the speed strap reads 1
    initial begin
        sclk_o  = 1'b0;
        sen_n_o = 1'b1;
        sdi_o   = 1'b1;
    end
    // MSB first; line sampled just before each link clock rise
    task automatic frame(input logic [15:0] word, output logic [15:0] resp);
        @(posedge core_clk_i);
        sen_n_o <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        for (int i = 15; i >= 0; i--) begin
            sdi_o <= word[i];
            repeat (4) @(posedge core_clk_i);
            resp[i] = sdo_line_i;
            sclk_o <= 1'b1;
            repeat (4) @(posedge core_clk_i);
            sclk_o <= 1'b0;
        end
        sen_n_o <= 1'b1;
        sdi_o   <= ~word[0];
        // Gap long enough for a write to land before the next frame
        repeat (8) @(posedge core_clk_i);
    endtask
endmodule

/* bench/irm_register_bank_chk.sv */
// Purpose: Port-level timing checks of the register bank
// Assumes: One core clock domain, synchronous active-high reset
// Notes:   Bound to the bank; sees its ports only
`timescale 1ns/1ps
module irm_register_bank_chk
    import irm_pkg::*;
(
    input wire logic       core_clk_i,
    input wire logic       rst_i,
    input wire logic       sen_n_i,
    input wire irm_err_t   err_src_i,
    input wire logic       corr_upd_i,
    input wire irm_corr_t  corr_i,
    input wire logic       ref_index_i,
    input wire logic       par_strobe_i,
    input wire logic [7:0] secondary_setup_o,
    input wire logic [7:0] fault_enable_mask_o,
    input wire logic [7:0] test_setup_o,
    input wire irm_corr_t  trims_o,
    input wire logic       error_o,
    input wire logic       index_strobe_pin_o,
    input wire logic       ready_o
);
    logic [11:0] init_cnt_r;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Cycles since release; saturates so it never wraps into the busy range
    always_ff @(posedge core_clk_i) begin
        if (rst_i) init_cnt_r <= 12'h000;
        else if (init_cnt_r != 12'h555) init_cnt_r <= init_cnt_r + 12'h001;
    end
    a_reset_values: assert property ($fell(rst_i) |-> fault_enable_mask_o == MASK_RST &&
        secondary_setup_o == SECOND_RST && test_setup_o == TEST_RST) else $error("bad reset values");
    a_init_busy: assert property (init_cnt_r < 12'h550 |-> !ready_o) else $error("ready too early");
    a_strobe_par: assert property (test_setup_o[TEST_STROBE_BIT] |=>
        index_strobe_pin_o == $past(par_strobe_i)) else $error("strobe not routed");
    a_strobe_idx: assert property (!test_setup_o[TEST_STROBE_BIT] |=>
        index_strobe_pin_o == $past(ref_index_i && !secondary_setup_o[SEC_INDEX_BIT])) else $error("index not routed");
    a_corr_block: assert property (corr_upd_i && secondary_setup_o[SEC_CORR_BIT] |=> $stable(trims_o))
        else $error("trims moved while off");
    a_corr_load: assert property (corr_upd_i && !secondary_setup_o[SEC_CORR_BIT] |=>
        trims_o == $past(corr_i)) else $error("trims not loaded");
    a_err_flag: assert property ((|(err_src_i & fault_enable_mask_o[5:0])) |=> error_o)
        else $error("masked error missing");
    a_regs_quiet: assert property (sen_n_i [*8] |=> $stable(fault_enable_mask_o) &&
        $stable(secondary_setup_o) && $stable(test_setup_o)) else $error("register moved without frame");
    c_error: cover property ($rose(error_o));
    c_corr: cover property (corr_upd_i && !secondary_setup_o[SEC_CORR_BIT]);
    c_strobe: cover property (test_setup_o[TEST_STROBE_BIT] && index_strobe_pin_o);
endmodule
bind irm_register_bank irm_register_bank_chk u_irm_register_bank_chk (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .sen_n_i(sen_n_i), .err_src_i(err_src_i),
    .corr_upd_i(corr_upd_i), .corr_i(corr_i), .ref_index_i(ref_index_i), .par_strobe_i(par_strobe_i),
    .secondary_setup_o(secondary_setup_o), .fault_enable_mask_o(fault_enable_mask_o),
    .test_setup_o(test_setup_o), .trims_o(trims_o), .error_o(error_o),
    .index_strobe_pin_o(index_strobe_pin_o), .ready_o(ready_o));

/* bench/testbench.sv */
// Purpose: Register bank tests through serial frames
// Assumes: Host model drives the frame pins, bench drives datapath levels
// Notes:   Reads wait on ready_o, bounded
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module testbench
    import irm_pkg::*;
;
    logic core_clk_i, rst, trg, up, dn, upd, ref_idx, pstb, sclk, sen_n, sdi, sdo, sdo_oe, err_o, frz;
    logic idx_pin, rdy;
    logic [3:0] chan;
    logic [7:0] prim, sec, mask, tst, ang, stp;
    logic [4:0] seq;
    logic [15:0] resp_w;
    logic [31:0] v;
    irm_cfg_pins_t cfg;
    irm_err_t err;
    irm_corr_t corr, trims;
    int checked, bad_count;
    localparam irm_corr_t MID = {GAIN_MID, OFFSET_MID, GAIN_MID, OFFSET_MID};
    // Pull-up on the open-drain data line
    wire line = sdo_oe ? sdo : 1'b1;
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    // Free-running sequencer count for aligned reads
    always @(posedge core_clk_i) seq <= seq + 5'h01;
    irm_host_model u_irm_host_model (.core_clk_i(core_clk_i), .sdo_line_i(line), .sclk_o(sclk), .sen_n_o(sen_n),
        .sdi_o(sdi));
    irm_register_bank u_irm_register_bank (.core_clk_i(core_clk_i), .rst_i(rst), .sclk_i(sclk), .sen_n_i(sen_n),
        .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .trg_i(trg), .channel_addr_pins_i(chan), .cfg_pins_i(cfg),
        .count_up_i(up), .count_dn_i(dn), .err_src_i(err), .phase_angle_i(ang), .phase_step_i(stp),
        .seq_cnt_i(seq), .corr_upd_i(upd), .corr_i(corr), .ref_index_i(ref_idx), .par_strobe_i(pstb),
        .primary_setup_o(prim), .secondary_setup_o(sec), .fault_enable_mask_o(mask), .test_setup_o(tst),
        .trims_o(trims), .error_o(err_o), .freeze_o(frz), .index_strobe_pin_o(idx_pin), .ready_o(rdy));
    task automatic finish_test;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic xfer(input logic [15:0] w);
        u_irm_host_model.frame(w, resp_w);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer({2'b00, OP_WR_ADDR, 4'h0, a});
        xfer({2'b00, OP_WR_DATA, 4'h0, d});
    endtask
    // Low capture, then two frames shift out low and high words
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        int n;
        xfer({2'b10, OP_RD_LOW, 4'h0, a});
        n = 0;
        while (rdy !== 1'b1 && n < 200) begin
            @(posedge core_clk_i);
            n++;
        end
        // Ready never came back: count it, the verdict then fails
        if (rdy !== 1'b1) bad_count++;
        xfer({2'b10, OP_RD_HIGH, 12'h000});
        v[15:0] = resp_w;
        xfer(16'hA000);
        v[31:16] = resp_w;
        `CHK(v, exp)
    endtask
    task automatic step(input int n, input logic dir);
        repeat (n) begin
            @(posedge core_clk_i);
            up <= dir;
            dn <= !dir;
            @(posedge core_clk_i);
            up <= 1'b0;
            dn <= 1'b0;
        end
    endtask
    task automatic pulse_upd;
        @(posedge core_clk_i);
        upd <= 1'b1;
        @(posedge core_clk_i);
        upd <= 1'b0;
        repeat (2) @(posedge core_clk_i);
    endtask
    initial begin
        #2_000_000;
        bad_count++;
        finish_test;
    end
    initial begin
        {rst, trg, up, dn, upd, ref_idx, pstb, seq, err} = {7'b1000001, 5'h00, 6'h00};
        chan = 4'h3;
        cfg = 5'b101_10;
        ang = 8'h5A;
        stp = 8'hF3;
        corr = 32'h1122_3344;
        repeat (10) @(posedge core_clk_i);
        rst <= 1'b0;
        repeat (1500) @(posedge core_clk_i);
        xfer({2'b00, OP_WR_CMD, 4'h0, CMD_CHANNEL});
        `CHK(prim, 8'hA5)
        `CHK(trims, MID)
        rdchk(RD_SETUP, {MASK_RST, SECOND_RST, 8'hA5, 8'h00});
        wr(WR_PRIMARY, 8'h8C);
        `CHK(prim, 8'h8C)
        wr(WR_SECOND, 8'h05);
        wr(WR_MASK, 8'hDF);
        rdchk(RD_SETUP, {8'hDF, 8'h05, 8'h8C, 8'h00});
        wr(WR_TEST, 8'h04);
        `CHK(idx_pin, 1'b1)
        wr(WR_TEST, 8'h00);
        `CHK(idx_pin, 1'b0)
        step(5, 1'b1);
        rdchk(RD_COUNT, {28'h0000005, 4'h0});
        step(7, 1'b0);
        rdchk(RD_MEASURED, {28'hFFFFFFE, 4'h0});
        trg <= 1'b1;
        // Let the synchronised edge store the count before it moves on
        repeat (4) @(posedge core_clk_i);
        step(3, 1'b1);
        trg <= 1'b0;
        rdchk(RD_MEASURED, {28'hFFFFFFE, 4'h1});
        rdchk(RD_MEASURED, {28'h0000001, 4'h0});
        rdchk(RD_PHASE, {8'h00, 8'hF3, 8'h00, 8'h5A});
        err <= 6'b001000;
        rdchk(RD_COUNT, {28'h0000001, 4'b0010});
        rdchk(RD_MEASURED, {28'h0000001, 4'b0100});
        rdchk(RD_SETUP, {8'hDF, 8'h05, 8'h8C, 8'h08});
        `CHK(frz, 1'b1)
        err <= 6'b000000;
        repeat (4) @(posedge core_clk_i);
        `CHK(err_o, 1'b1)
        xfer({2'b00, OP_WR_CMD, 4'h0, CMD_CLR_CNT});
        `CHK(err_o, 1'b0)
        rdchk(RD_COUNT, 32'h0000_0000);
        pulse_upd();
        `CHK(trims, MID)
        wr(WR_SINE_GAIN_TRIM, 8'h11);
        rdchk(RD_SINE, 32'h0000_0011);
        wr(WR_SECOND, 8'h00);
        pulse_upd();
        `CHK(trims, corr)
        xfer({2'b00, OP_WR_CMD, 4'h0, CMD_MIDSCALE});
        `CHK(trims, MID)
        rdchk(8'h02, 32'h0000_0000);
        xfer({2'b01, OP_WR_ADDR, 4'h3, WR_TEST});
        xfer({2'b01, OP_WR_DATA, 4'h5, 8'h04});
        `CHK(tst, 8'h00)
        xfer({2'b01, OP_WR_DATA, 4'h3, 8'h04});
        `CHK(tst, 8'h04)
        finish_test;
    end
endmodule
